// file: rtl/msc_pkg.sv
// Package with register map, field positions, timing and states of the monitor ADC sequencer
//
// Behaviour
// - Each enabled channel is converted in at most 25 ms.
// - A conversion set visits only the enabled channels, so it lasts 25 ms times the enabled channel count.
// - With the repeat-mode bit at 0 one set is run after a start request and the results are then published.
// - With the repeat-mode bit at 1 a complete set is run and the results are refreshed once every second.
// - Conversion begins when the start bit (bit 14) is written to 1 and never runs while it is 0.
// - In one-shot mode the device clears the start bit itself once the set has completed.
// - The range select bit picks 2.04 V at 8 mV per step (0) or 3.06 V at 12 mV per step (1, default) for two channels.
// - Channels are read in the order battery, system voltage, charge, discharge, input current, power, bus, comparator.
// - Bits 7 to 0 each enable one channel with 1, disable with 0, and reset to 0.
// - The converter stays inactive whenever low power mode is active, whatever enable and start say.
// - With the light-load exit bit set in pass-through, input current below the low threshold for over 500 us exits to buck-boost.
// - After such an exit, input current above the high threshold for over 500 us returns to pass-through automatically.
// - The configuration register resets to 2000h with reserved bits 11 to 8 at zero.
package msc_pkg;

  localparam logic [7:0]  ADC_CONFIGURATION_ADDR = 8'h35;
  localparam logic [15:0] ADC_CONFIGURATION_RST  = 16'h2000;

  localparam int REPEAT_MODE_BIT  = 15;
  localparam int START_BIT        = 14;
  localparam int RANGE_SELECT_BIT = 13;
  localparam int LIGHT_EXIT_BIT   = 12;
  localparam int CHAN_EN_LSB      = 0;
  localparam int CHAN_EN_MSB      = 7;

  localparam int CLK_HZ        = 20_000_000;
  localparam int CONV_TIME_MS  = 25;
  localparam int PERIOD_TIME_S = 1;
  localparam int DWELL_TIME_US = 500;

  // Longest times round down, least times round up
  localparam int CONV_CYC   = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int PERIOD_CYC = CLK_HZ * PERIOD_TIME_S;
  localparam int DWELL_CYC  = (CLK_HZ / 1000 * DWELL_TIME_US + 999) / 1000;

  localparam int CNT_W   = 25;
  localparam int DWELL_W = 16;

  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_WAIT = 2'b11
  } msc_seq_e;

  typedef enum logic [2:0]
  {
    CH_BATTERY      = 3'h0,
    CH_SYSTEM_VOLT  = 3'h1,
    CH_CHARGE_CURR  = 3'h2,
    CH_DISCHG_CURR  = 3'h3,
    CH_INPUT_CURR   = 3'h4,
    CH_SYSTEM_POWER = 3'h5,
    CH_BUS_VOLT     = 3'h6,
    CH_COMPARATOR   = 3'h7
  } msc_chan_e;

endpackage

// file: rtl/msc_ll_if.sv
// Interface between the sequencer top and the light-load exit filter
`timescale 1ns/1ps
interface msc_ll_if;
  logic enable;
  logic ptm_active;
  logic iin_below;
  logic iin_above;
  logic exit_active;

  modport ctrl
  (
    output enable,
    output ptm_active,
    output iin_below,
    output iin_above,
    input  exit_active
  );

  modport filt
  (
    input  enable,
    input  ptm_active,
    input  iin_below,
    input  iin_above,
    output exit_active
  );
endinterface

// file: rtl/msc_light_load.sv
// Light-load exit filter that drops pass-through operation into buck-boost and back
`timescale 1ns/1ps
module msc_light_load
#(
  parameter int DWELL_CYC = msc_pkg::DWELL_CYC
)
(
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  msc_ll_if.filt    ll
);
  import msc_pkg::*;

  logic [DWELL_W-1:0] dwell_r;
  logic               exit_r;
  logic               cond;

  // Current that qualifies for the next transition depends on the present direction
  assign cond = exit_r ? ll.iin_above : ll.iin_below;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dwell_r <= '0;
      exit_r  <= 1'b0;
    end
    else if (!ll.enable || !ll.ptm_active)
    begin
      // Feature off or pass-through not selected: nothing to exit from
      dwell_r <= '0;
      exit_r  <= 1'b0;
    end
    else if (!cond)
    begin
      dwell_r <= '0;
    end
    else if (dwell_r == DWELL_W'(DWELL_CYC))
    begin
      // Condition held for more than the dwell time
      exit_r  <= ~exit_r;
      dwell_r <= '0;
    end
    else
    begin
      dwell_r <= dwell_r + DWELL_W'(1);
    end
  end

  assign ll.exit_active = exit_r;

endmodule

// file: rtl/msc_sequencer.sv
// Monitor ADC sequencer with its configuration register and light-load exit control
`timescale 1ns/1ps
module msc_sequencer
#(
  parameter int CONV_CYC   = msc_pkg::CONV_CYC,
  parameter int PERIOD_CYC = msc_pkg::PERIOD_CYC,
  parameter int DWELL_CYC  = msc_pkg::DWELL_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        low_power_i,
  input  wire logic        ptm_active_i,
  input  wire logic        iin_below_exit_i,
  input  wire logic        iin_above_return_i,
  output logic             adc_active_o,
  output msc_pkg::msc_chan_e adc_chan_o,
  output logic             chan_sample_o,
  output logic             results_update_o,
  output logic             range_select_o,
  output logic             passthru_exit_o
);
  import msc_pkg::*;

  logic [15:0]      cfg_r;
  logic [15:0]      rdata_r;
  msc_seq_e         state_r;
  logic [2:0]       chan_r;
  logic [CNT_W-1:0] conv_cnt_r;
  logic [CNT_W-1:0] period_cnt_r;
  logic             sample_r;
  logic             update_r;
  logic [1:0]       below_sync_r;
  logic [1:0]       above_sync_r;

  logic       cfg_hit;
  logic [7:0] chan_en;
  logic       start;
  logic       repeat_mode;
  logic       go;
  logic       conv_last;
  logic       period_end;
  logic [3:0] first_chan;
  logic [3:0] after_chan;
  logic       set_done;

  msc_ll_if ll_if ();

  // Lowest enabled channel at or above 'from'; bit 3 flags that one exists
  function automatic logic [3:0] next_chan(input logic [7:0] en, input logic [3:0] from);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (en[i] && (4'(i) >= from))
      begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  assign cfg_hit     = reg_wr_i && (reg_addr_i == ADC_CONFIGURATION_ADDR);
  assign chan_en     = cfg_r[CHAN_EN_MSB:CHAN_EN_LSB];
  assign start       = cfg_r[START_BIT];
  assign repeat_mode = cfg_r[REPEAT_MODE_BIT];
  assign go          = start && !low_power_i;
  assign conv_last   = (conv_cnt_r == CNT_W'(CONV_CYC - 1));
  assign period_end  = (period_cnt_r >= CNT_W'(PERIOD_CYC - 1));
  // Fixed visiting order is the channel index order, skipping disabled ones
  assign first_chan  = next_chan(chan_en, 4'h0);
  assign after_chan  = next_chan(chan_en, {1'b0, chan_r} + 4'h1);

  // A set ends after the last enabled channel, or at once when none is enabled
  always_comb
  begin
    set_done = 1'b0;
    case (state_r)
      SEQ_IDLE: set_done = go && !first_chan[3];
      SEQ_CONV: set_done = go && conv_last && !after_chan[3];
      SEQ_WAIT: set_done = go && period_end && !first_chan[3];
      default:  set_done = 1'b0;
    endcase
  end

  // Configuration register
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_r <= ADC_CONFIGURATION_RST;
    end
    else if (cfg_hit)
    begin
      // A host write in the completion cycle wins, so a fresh start is not lost
      cfg_r <= reg_wdata_i;
    end
    else if (set_done && !repeat_mode)
    begin
      cfg_r[START_BIT] <= 1'b0;
    end
  end

  // Read data is the register itself; other addresses read zero
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_r <= '0;
    end
    else
    begin
      rdata_r <= (reg_addr_i == ADC_CONFIGURATION_ADDR) ? cfg_r : 16'h0000;
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r      <= SEQ_IDLE;
      chan_r       <= 3'h0;
      conv_cnt_r   <= '0;
      period_cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        SEQ_IDLE:
        begin
          if (go)
          begin
            period_cnt_r <= '0;
            conv_cnt_r   <= '0;
            chan_r       <= first_chan[2:0];
            if (first_chan[3])
            begin
              state_r <= SEQ_CONV;
            end
            else if (repeat_mode)
            begin
              state_r <= SEQ_WAIT;
            end
          end
        end
        SEQ_CONV:
        begin
          period_cnt_r <= period_cnt_r + CNT_W'(1);
          if (!go)
          begin
            // Low power or a cleared start aborts the set
            state_r <= SEQ_IDLE;
          end
          else if (conv_last)
          begin
            conv_cnt_r <= '0;
            if (after_chan[3])
            begin
              chan_r <= after_chan[2:0];
            end
            else if (repeat_mode)
            begin
              state_r <= SEQ_WAIT;
            end
            else
            begin
              state_r <= SEQ_IDLE;
            end
          end
          else
          begin
            conv_cnt_r <= conv_cnt_r + CNT_W'(1);
          end
        end
        SEQ_WAIT:
        begin
          if (!go || !repeat_mode)
          begin
            state_r <= SEQ_IDLE;
          end
          else if (period_end)
          begin
            // Sets start one period apart, measured from the previous start
            period_cnt_r <= '0;
            conv_cnt_r   <= '0;
            chan_r       <= first_chan[2:0];
            if (first_chan[3])
            begin
              state_r <= SEQ_CONV;
            end
          end
          else
          begin
            period_cnt_r <= period_cnt_r + CNT_W'(1);
          end
        end
        default:
        begin
          state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Result strobes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sample_r <= 1'b0;
      update_r <= 1'b0;
    end
    else
    begin
      sample_r <= (state_r == SEQ_CONV) && go && conv_last;
      update_r <= set_done;
    end
  end

  // Comparator levels come from the analog side and are synchronised
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      below_sync_r <= 2'b00;
      above_sync_r <= 2'b00;
    end
    else
    begin
      below_sync_r <= {below_sync_r[0], iin_below_exit_i};
      above_sync_r <= {above_sync_r[0], iin_above_return_i};
    end
  end

  assign ll_if.enable     = cfg_r[LIGHT_EXIT_BIT];
  assign ll_if.ptm_active = ptm_active_i;
  assign ll_if.iin_below  = below_sync_r[1];
  assign ll_if.iin_above  = above_sync_r[1];

  msc_light_load
  #(
    .DWELL_CYC (DWELL_CYC)
  )
  u_light_load
  (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ll       (ll_if.filt)
  );

  assign reg_rdata_o      = rdata_r;
  assign adc_active_o     = (state_r == SEQ_CONV);
  assign adc_chan_o       = msc_chan_e'(chan_r);
  assign chan_sample_o    = sample_r;
  assign results_update_o = update_r;
  assign range_select_o   = cfg_r[RANGE_SELECT_BIT];
  assign passthru_exit_o  = ll_if.exit_active;

endmodule

// file: sim/msc_host_model.sv
// Host model that writes and reads the configuration register
`timescale 1ns/1ps
module msc_host_model
(
  input  wire logic        clk_i,
  output logic             reg_wr_o,
  output logic [7:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i
);
  initial
  begin
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h35;
    reg_wdata_o = 16'h0000;
  end

  // Data is inverted after use so a stale word never looks valid
  task automatic wr(input logic [15:0] d);
    @(negedge clk_i);
    reg_addr_o = 8'h35;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    @(negedge clk_i);
    d = reg_rdata_i;
    reg_addr_o = 8'h35;
  endtask
endmodule

// file: sim/msc_sequencer_asserts.sv
// Port assertions for the monitor ADC sequencer
`timescale 1ns/1ps
module msc_sequencer_asserts
#(
  parameter int CONV_CYC = msc_pkg::CONV_CYC
)
(
  input wire logic               clk_i,
  input wire logic               arst_n_i,
  input wire logic               reg_wr_i,
  input wire logic [7:0]         reg_addr_i,
  input wire logic [15:0]        reg_wdata_i,
  input wire logic [15:0]        reg_rdata_o,
  input wire logic               low_power_i,
  input wire logic               ptm_active_i,
  input wire logic               adc_active_o,
  input wire msc_pkg::msc_chan_e adc_chan_o,
  input wire logic               results_update_o,
  input wire logic               range_select_o,
  input wire logic               passthru_exit_o
);
  import msc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [24:0] cnt_r;
  logic        act_q_r;
  msc_chan_e   chan_q_r;

  // Counts clock cycles spent on one channel
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_r <= '0;
    else if (adc_active_o && act_q_r && adc_chan_o == chan_q_r)
      cnt_r <= cnt_r + 25'h1;
    else
      cnt_r <= {24'h0, adc_active_o};
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      act_q_r <= 1'b0;
      chan_q_r <= CH_BATTERY;
    end
    else
    begin
      act_q_r <= adc_active_o;
      chan_q_r <= adc_chan_o;
    end
  end

  sequence s_go;
    reg_wr_i && reg_addr_i == 8'h35 && reg_wdata_i[15:14] == 2'b01 && reg_wdata_i[7:0] != 8'h00;
  endsequence
  sequence s_cfg_wr;
    reg_wr_i && reg_addr_i == 8'h35 ##1 reg_addr_i == 8'h35 && !reg_wr_i;
  endsequence

  property p_start;
    s_go ##1 (!low_power_i && !reg_wr_i) |=> adc_active_o;
  endproperty
  property p_lp_off;
    low_power_i |=> !adc_active_o;
  endproperty
  property p_len;
    cnt_r <= CONV_CYC;
  endproperty
  property p_order;
    adc_active_o && $past(adc_active_o) && adc_chan_o != $past(adc_chan_o) |-> adc_chan_o > $past(adc_chan_o);
  endproperty
  property p_upd;
    results_update_o |-> !adc_active_o ##1 !results_update_o;
  endproperty
  property p_lp_upd;
    low_power_i [*3] |-> !results_update_o;
  endproperty
  property p_range;
    reg_wr_i && reg_addr_i == 8'h35 |=> range_select_o == $past(reg_wdata_i[13]);
  endproperty
  property p_wr_rd;
    s_cfg_wr |=> {reg_rdata_o[15], reg_rdata_o[13:0]} == {$past(reg_wdata_i[15], 2), $past(reg_wdata_i[13:0], 2)};
  endproperty
  property p_exit;
    !ptm_active_i |=> !passthru_exit_o;
  endproperty

  a_start: assert property (p_start) else $error("Conversion did not start");
  a_lp_off: assert property (p_lp_off) else $error("Active in low power");
  a_len: assert property (p_len) else $error("Channel too long");
  a_order: assert property (p_order) else $error("Channel order wrong");
  a_upd: assert property (p_upd) else $error("Update pulse wrong");
  a_lp_upd: assert property (p_lp_upd) else $error("Update in low power");
  a_range: assert property (p_range) else $error("Range select wrong");
  a_wr_rd: assert property (p_wr_rd) else $error("Readback wrong");
  a_exit: assert property (p_exit) else $error("Exit without pass-through");
endmodule

bind msc_sequencer msc_sequencer_asserts #(.CONV_CYC(CONV_CYC)) msc_sequencer_asserts_i (.clk_i, .arst_n_i,
  .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .low_power_i, .ptm_active_i, .adc_active_o,
  .adc_chan_o, .results_update_o, .range_select_o, .passthru_exit_o);

// file: sim/tb_msc_sequencer.sv
// Testbench for the monitor ADC sequencer
`timescale 1ns/1ps
module tb_msc_sequencer;
  import msc_pkg::*;
  logic        clk_i;
  logic        arst_n;
  logic        wr;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        low_power;
  logic        pass_through_operation;
  logic        below;
  logic        above;
  logic        adc_active_o;
  msc_chan_e   adc_chan_o;
  logic        sample;
  logic        results_update_o;
  logic        range_select_o;
  logic        exit_o;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          act_n = 0;
  int          upd_n = 0;
  int          smp_n = 0;
  logic [31:0] ord = '0;
  logic        act_q = 1'b0;
  msc_chan_e   chan_q;

  always #25 clk_i = ~clk_i;

  msc_host_model msc_host_model_i (.clk_i(clk_i), .reg_wr_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_rdata_i(rdata));

  msc_sequencer #(.CONV_CYC(20), .PERIOD_CYC(300), .DWELL_CYC(8)) msc_sequencer_i (.clk_i(clk_i),
    .arst_n_i(arst_n), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .low_power_i(low_power), .ptm_active_i(pass_through_operation), .iin_below_exit_i(below), .iin_above_return_i(above),
    .adc_active_o(adc_active_o), .adc_chan_o(adc_chan_o), .chan_sample_o(sample),
    .results_update_o(results_update_o), .range_select_o(range_select_o), .passthru_exit_o(exit_o));

  // Each new channel is logged as index plus one, so channel 0 still shows
  always @(negedge clk_i)
  begin
    if (adc_active_o === 1'b1)
    begin
      act_n++;
      if (!act_q || adc_chan_o != chan_q)
        ord = {ord[27:0], {1'b0, adc_chan_o} + 4'h1};
    end
    if (results_update_o === 1'b1)
      upd_n++;
    if (sample === 1'b1)
      smp_n++;
    act_q = adc_active_o;
    chan_q = adc_chan_o;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic clr();
    @(posedge clk_i);
    act_n = 0;
    upd_n = 0;
    smp_n = 0;
    ord = '0;
  endtask

  task automatic wait_upd(output int n);
    for (n = 1; n <= 1000; n++)
    begin
      @(negedge clk_i);
      if (results_update_o === 1'b1)
        return;
    end
    error_cnt++;
    $display("Error update: expected pulse, seen none");
    wrap_up();
  endtask

  task automatic t_reset();
    logic [15:0] d;
    msc_host_model_i.rd(8'h35, d);
    chk("config reset", 32'h2000, {16'h0, d});
    chk("range reset", 32'h1, {31'h0, range_select_o});
  endtask

  task automatic run_once(input logic [15:0] w, input int ea, input logic [31:0] eo);
    int n;
    logic [15:0] d;
    clr();
    msc_host_model_i.wr(w);
    wait_upd(n);
    @(posedge clk_i);
    chk("active cycles", 32'(ea), 32'(act_n));
    chk("channel order", eo, ord);
    chk("channel samples", 32'($countones(w[7:0])), 32'(smp_n));
    msc_host_model_i.rd(8'h35, d);
    chk("config after set", {16'h0, w & 16'hbfff}, {16'h0, d});
    chk("range select", {31'h0, w[13]}, {31'h0, range_select_o});
  endtask

  task automatic t_nostart();
    clr();
    msc_host_model_i.wr(16'h00ff);
    repeat (50) @(negedge clk_i);
    chk("active without start", 32'h0, 32'(act_n));
  endtask

  task automatic t_cont();
    int n;
    logic [15:0] d;
    clr();
    msc_host_model_i.wr(16'hc080);
    wait_upd(n);
    wait_upd(n);
    chk("set period", 32'h12c, 32'(n));
    msc_host_model_i.rd(8'h35, d);
    chk("start kept", 32'hc080, {16'h0, d});
    msc_host_model_i.wr(16'h0080);
    repeat (400) @(negedge clk_i);
    chk("updates", 32'h2, 32'(upd_n));
  endtask

  task automatic t_lowpower();
    clr();
    // Inputs move on the falling edge only
    @(negedge clk_i);
    low_power = 1'b1;
    msc_host_model_i.wr(16'h40ff);
    repeat (30) @(negedge clk_i);
    chk("active in low power", 32'h0, 32'(act_n));
    low_power = 1'b0;
    repeat (30) @(negedge clk_i);
    low_power = 1'b1;
    repeat (200) @(negedge clk_i);
    chk("started", 32'h1, {31'h0, act_n > 0});
    chk("updates", 32'h0, 32'(upd_n));
    msc_host_model_i.wr(16'h0000);
    low_power = 1'b0;
  endtask

  task automatic t_light();
    msc_host_model_i.wr(16'h1000);
    pass_through_operation = 1'b1;
    below = 1'b1;
    repeat (8) @(negedge clk_i);
    chk("early exit", 32'h0, {31'h0, exit_o});
    repeat (12) @(negedge clk_i);
    chk("exit", 32'h1, {31'h0, exit_o});
    below = 1'b0;
    above = 1'b1;
    repeat (8) @(negedge clk_i);
    chk("early return", 32'h1, {31'h0, exit_o});
    repeat (12) @(negedge clk_i);
    chk("return", 32'h0, {31'h0, exit_o});
    above = 1'b0;
    below = 1'b1;
    repeat (20) @(negedge clk_i);
    chk("exit again", 32'h1, {31'h0, exit_o});
    // Leaving pass-through must drop the exit at once
    pass_through_operation = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("exit cleared", 32'h0, {31'h0, exit_o});
    below = 1'b0;
  endtask

  initial
  begin
    clk_i = 1'b0;
    arst_n = 1'b0;
    low_power = 1'b0;
    pass_through_operation = 1'b0;
    below = 1'b0;
    above = 1'b0;
    repeat (6) @(negedge clk_i);
    arst_n = 1'b1;
    t_reset();
    run_once(16'h4005, 40, 32'h13);
    run_once(16'h60ff, 160, 32'h12345678);
    run_once(16'h4000, 0, 32'h0);
    t_nostart();
    t_cont();
    t_lowpower();
    t_light();
    wrap_up();
  end
endmodule
